// File: design/sfcd_consts.svh
// Purpose: constants of the serial flash command decoder
// Assumes: included by the table and decoder design files; the package does not include it
// Notes:   opcodes, encodings and counts; no logic here
`ifndef SFCD_CONSTS_SVH
`define SFCD_CONSTS_SVH

// Protocol select encodings
`define SFCD_PROTO_EXT    2'h0
`define SFCD_PROTO_DUAL   2'h1
`define SFCD_PROTO_QUAD   2'h2

// Protocol permission masks {quad, dual, extended}
`define SFCD_OK_ALL       3'h7
`define SFCD_OK_EXT       3'h1
`define SFCD_OK_EXT_DUAL  3'h3
`define SFCD_OK_EXT_QUAD  3'h5
`define SFCD_OK_NONE      3'h0

// Address length kinds
`define SFCD_AC_NONE      2'h0
`define SFCD_AC_THREE     2'h1
`define SFCD_AC_VAR       2'h2
`define SFCD_AC_FOUR      2'h3
`define SFCD_ABYTES_3     3'h3
`define SFCD_ABYTES_4     3'h4

// Data direction and address mode actions
`define SFCD_DIR_NONE     2'h0
`define SFCD_DIR_OUT      2'h1
`define SFCD_DIR_IN       2'h2
`define SFCD_ACT_NONE     2'h0
`define SFCD_ACT_ENTER4   2'h1
`define SFCD_ACT_EXIT4    2'h2

// Data byte limits; zero means unbounded stream
`define SFCD_DMAX_STREAM  5'h00
`define SFCD_DMAX_ID      5'h14
`define SFCD_DMAX_ONE     5'h01
`define SFCD_DMAX_TWO     5'h02

// Clock edges that complete an opcode per protocol
`define SFCD_EDGES_EXT    4'h8
`define SFCD_EDGES_DUAL   4'h4
`define SFCD_EDGES_QUAD   4'h2

// Opcodes
`define SFCD_OP_RESET_EN  8'h66
`define SFCD_OP_RESET_MEM 8'h99
`define SFCD_OP_ID_A      8'h9e
`define SFCD_OP_ID_B      8'h9f
`define SFCD_OP_ID_MULTI  8'haf
`define SFCD_OP_DISC      8'h5a
`define SFCD_OP_READ      8'h03
`define SFCD_OP_FAST      8'h0b
`define SFCD_OP_DOUT      8'h3b
`define SFCD_OP_DIO       8'hbb
`define SFCD_OP_QOUT      8'h6b
`define SFCD_OP_QIO       8'heb
`define SFCD_OP_DE_FAST   8'h0d
`define SFCD_OP_DE_DOUT   8'h3d
`define SFCD_OP_DE_DIO    8'hbd
`define SFCD_OP_DE_QOUT   8'h6d
`define SFCD_OP_DE_QIO    8'hed
`define SFCD_OP_QIO_WORD  8'he7
`define SFCD_OP_READ4     8'h13
`define SFCD_OP_FAST4     8'h0c
`define SFCD_OP_DOUT4     8'h3c
`define SFCD_OP_DIO4      8'hbc
`define SFCD_OP_QOUT4     8'h6c
`define SFCD_OP_QIO4      8'hec
`define SFCD_OP_DE_FAST4  8'h0e
`define SFCD_OP_DE_DIO4   8'hbe
`define SFCD_OP_DE_QIO4   8'hee
`define SFCD_OP_WREN      8'h06
`define SFCD_OP_WRDIS     8'h04
`define SFCD_OP_RD_STAT   8'h05
`define SFCD_OP_RD_FLAG   8'h70
`define SFCD_OP_RD_NVCFG  8'hb5
`define SFCD_OP_RD_VCFG   8'h85
`define SFCD_OP_RD_EVCFG  8'h65
`define SFCD_OP_RD_EXTA   8'hc8
`define SFCD_OP_RD_GP     8'h96
`define SFCD_OP_WR_STAT   8'h01
`define SFCD_OP_WR_NVCFG  8'hb1
`define SFCD_OP_ENTER4    8'hb7
`define SFCD_OP_EXIT4     8'he9

`endif

// File: design/sfcd_pkg.sv
// Purpose: types shared by the command decoder files
// Assumes: constants come from sfcd_consts.svh
// Notes:   one table entry describes one opcode
package sfcd_pkg;

	// Per-opcode description held in the command table
	typedef struct packed {
		logic [2:0] ok;
		logic [1:0] acode;
		logic [3:0] dum_ext;
		logic [3:0] dum_dual;
		logic [3:0] dum_quad;
		logic [2:0] ext_alines;
		logic [2:0] ext_dlines;
		logic       dtr;
		logic [1:0] act;
		logic [1:0] dir;
		logic [4:0] dmax;
	} sfcd_entry_type;

	// Decoder sequence on the system clock
	typedef enum {ST_IDLE, ST_LOOK, ST_EMIT} sfcd_state_type;

endpackage : sfcd_pkg

// File: design/sfcd_cmd_rom.sv
// Purpose: opcode description table with registered read data
// Assumes: opcode presented one cycle before the entry is used
// Notes:   unknown opcodes read as an entry with no protocol allowed
`timescale 1ns/1ps
`include "sfcd_consts.svh"
module sfcd_cmd_rom (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	input  wire logic [7:0]            op_in,
	output sfcd_pkg::sfcd_entry_type   entry_out
);
	import sfcd_pkg::*;

	// Builds one entry from its columns
	function automatic sfcd_entry_type mk(input logic [2:0] ok,
		input logic [1:0] ac, input logic [3:0] de, input logic [3:0] dd,
		input logic [3:0] dq, input logic [2:0] al, input logic [2:0] dl,
		input logic dtr, input logic [1:0] act, input logic [1:0] dir,
		input logic [4:0] dm);
		mk = '{ok, ac, de, dd, dq, al, dl, dtr, act, dir, dm};
	endfunction : mk

	// Lookup table; a plain case keeps it a constant structure
	function automatic sfcd_entry_type lookup(input logic [7:0] op);
		sfcd_entry_type e;
		e = mk(`SFCD_OK_NONE, `SFCD_AC_NONE, 4'h0, 4'h0, 4'h0, 3'h0,
			3'h0, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_NONE, 5'h00);
		case (op)
			`SFCD_OP_ID_A, `SFCD_OP_ID_B: e = mk(`SFCD_OK_EXT, `SFCD_AC_NONE,
				4'h0, 4'h0, 4'h0, 3'h0, 3'h1, 1'b0, `SFCD_ACT_NONE,
				`SFCD_DIR_OUT, `SFCD_DMAX_ID);
			`SFCD_OP_ID_MULTI: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT,
				`SFCD_DMAX_ID);
			`SFCD_OP_DISC: e = mk(`SFCD_OK_ALL, `SFCD_AC_THREE, 4'h8, 4'h8,
				4'h8, 3'h1, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT,
				`SFCD_DMAX_STREAM);
			`SFCD_OP_READ: e = mk(`SFCD_OK_EXT, `SFCD_AC_VAR, 4'h0, 4'h0, 4'h0,
				3'h1, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_FAST: e = mk(`SFCD_OK_ALL, `SFCD_AC_VAR, 4'h8, 4'h8, 4'ha,
				3'h1, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DOUT: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_VAR, 4'h8, 4'h8,
				4'h0, 3'h1, 3'h2, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DIO: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_VAR, 4'h8, 4'h8,
				4'h0, 3'h2, 3'h2, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_QOUT: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_VAR, 4'h8, 4'h0,
				4'ha, 3'h1, 3'h4, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_QIO: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_VAR, 4'ha, 4'h0,
				4'ha, 3'h4, 3'h4, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_FAST: e = mk(`SFCD_OK_ALL, `SFCD_AC_VAR, 4'h6, 4'h6,
				4'h8, 3'h1, 3'h1, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_DOUT: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_VAR, 4'h6,
				4'h6, 4'h0, 3'h1, 3'h2, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_DIO: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_VAR, 4'h6,
				4'h6, 4'h0, 3'h2, 3'h2, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_QOUT: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_VAR, 4'h6,
				4'h0, 4'h8, 3'h1, 3'h4, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_QIO: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_VAR, 4'h8,
				4'h0, 4'h8, 3'h4, 3'h4, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_QIO_WORD: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_VAR, 4'h4,
				4'h0, 4'h4, 3'h4, 3'h4, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_READ4: e = mk(`SFCD_OK_EXT, `SFCD_AC_FOUR, 4'h0, 4'h0,
				4'h0, 3'h1, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_FAST4: e = mk(`SFCD_OK_ALL, `SFCD_AC_FOUR, 4'h8, 4'h8,
				4'ha, 3'h1, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DOUT4: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_FOUR, 4'h8, 4'h8,
				4'h0, 3'h1, 3'h2, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DIO4: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_FOUR, 4'h8, 4'h8,
				4'h0, 3'h2, 3'h2, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_QOUT4: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_FOUR, 4'h8, 4'h0,
				4'ha, 3'h1, 3'h4, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_QIO4: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_FOUR, 4'ha, 4'h0,
				4'ha, 3'h4, 3'h4, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_FAST4: e = mk(`SFCD_OK_ALL, `SFCD_AC_FOUR, 4'h6, 4'h6,
				4'h8, 3'h1, 3'h1, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_DIO4: e = mk(`SFCD_OK_EXT_DUAL, `SFCD_AC_FOUR, 4'h6,
				4'h6, 4'h0, 3'h2, 3'h2, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_DE_QIO4: e = mk(`SFCD_OK_EXT_QUAD, `SFCD_AC_FOUR, 4'h8,
				4'h0, 4'h8, 3'h4, 3'h4, 1'b1, `SFCD_ACT_NONE, `SFCD_DIR_OUT, 5'h00);
			`SFCD_OP_WREN, `SFCD_OP_WRDIS, `SFCD_OP_RESET_EN,
			`SFCD_OP_RESET_MEM: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h0, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_NONE, 5'h00);
			`SFCD_OP_RD_STAT, `SFCD_OP_RD_FLAG, `SFCD_OP_RD_NVCFG,
			`SFCD_OP_RD_VCFG, `SFCD_OP_RD_EVCFG,
			`SFCD_OP_RD_EXTA: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT,
				`SFCD_DMAX_STREAM);
			`SFCD_OP_RD_GP: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h8, 4'h8,
				4'h8, 3'h0, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_OUT,
				`SFCD_DMAX_STREAM);
			`SFCD_OP_WR_STAT: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_IN,
				`SFCD_DMAX_ONE);
			`SFCD_OP_WR_NVCFG: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h1, 1'b0, `SFCD_ACT_NONE, `SFCD_DIR_IN,
				`SFCD_DMAX_TWO);
			`SFCD_OP_ENTER4: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h0, 1'b0, `SFCD_ACT_ENTER4, `SFCD_DIR_NONE, 5'h00);
			`SFCD_OP_EXIT4: e = mk(`SFCD_OK_ALL, `SFCD_AC_NONE, 4'h0, 4'h0,
				4'h0, 3'h0, 3'h0, 1'b0, `SFCD_ACT_EXIT4, `SFCD_DIR_NONE, 5'h00);
			default: e = e;
		endcase
		lookup = e;
	endfunction : lookup

	// Registered read port
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			entry_out <= '0;
		end else begin
			entry_out <= lookup(op_in);
		end
	end

endmodule : sfcd_cmd_rom

// File: design/sfcd_decoder.sv
// Purpose: decode serial flash opcodes into phase descriptions
// Assumes: protocol select is stable for a whole frame
// Notes:   opcode capture runs on the serial clock, decode on mclk
`timescale 1ns/1ps
`include "sfcd_consts.svh"
module sfcd_decoder #(
	parameter int SYNC_STAGES = 2
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic [3:0]  dq_in,
	input  wire logic [1:0]  proto_in,
	output logic             cmd_valid_out,
	output logic             cmd_illegal_out,
	output logic [7:0]       opcode_out,
	output logic [2:0]       cmd_lines_out,
	output logic [2:0]       addr_lines_out,
	output logic [2:0]       data_lines_out,
	output logic [2:0]       addr_bytes_out,
	output logic [3:0]       dummy_out,
	output logic [1:0]       data_dir_out,
	output logic [4:0]       data_max_out,
	output logic             dtr_out,
	output logic             four_byte_mode_out
);
	import sfcd_pkg::*;

	// Fewer than two stages would let logic read a metastable flop
	if (SYNC_STAGES < 2) begin : g_chk
		$error("SYNC_STAGES must be at least 2");
	end

	// Lines for a phase: extended value, or the protocol width
	function automatic logic [2:0] lines_for(input logic [1:0] proto,
		input logic [2:0] ext_val);
		case (proto)
			`SFCD_PROTO_EXT:  lines_for = ext_val;
			`SFCD_PROTO_DUAL: lines_for = 3'h2;
			`SFCD_PROTO_QUAD: lines_for = 3'h4;
			default:          lines_for = 3'h0;
		endcase
	endfunction : lines_for

	// Pick one of three per-protocol values
	function automatic logic [7:0] by_proto(input logic [1:0] proto,
		input logic [7:0] v_ext, input logic [7:0] v_dual,
		input logic [7:0] v_quad);
		case (proto)
			`SFCD_PROTO_EXT:  by_proto = v_ext;
			`SFCD_PROTO_DUAL: by_proto = v_dual;
			`SFCD_PROTO_QUAD: by_proto = v_quad;
			default:          by_proto = 8'h00;
		endcase
	endfunction : by_proto

	logic [3:0]     edge_cnt_reg;
	logic [3:0]     edge_cnt_next;
	logic [7:0]     ext_sh_reg;
	logic [7:0]     dual_sh_reg;
	logic [7:0]     quad_sh_reg;
	logic [7:0]     cand     [3];
	logic [2:0]     stage_hit;
	logic [7:0]     hold_reg [3];
	logic [2:0]     tog_reg;
	logic           link_rst_n;
	logic [2:0]     sync_reg [SYNC_STAGES+1];
	logic [2:0]     stage_ev;
	logic           ev_mine;
	logic [7:0]     op_pick;
	sfcd_state_type state_reg;
	sfcd_state_type state_next;
	logic [7:0]     opcode_reg;
	logic [1:0]     proto_reg;
	sfcd_entry_type entry;
	logic           emit;
	logic           legal;
	logic [2:0]     abytes;
	logic [7:0]     dummy_wide;
	logic [3:0]     dummy_sel;
	logic [2:0]     alines;
	logic [2:0]     dlines;
	logic [2:0]     clines;
	logic           four_next;

	// Frame end clears the capture logic; the serial clock may stop
	assign link_rst_n = rst_n_in & ~cs_n_in;

	// Shift candidates for all three widths in parallel
	assign cand[0] = {ext_sh_reg[6:0], dq_in[0]};
	assign cand[1] = {dual_sh_reg[5:0], dq_in[1:0]};
	assign cand[2] = {quad_sh_reg[3:0], dq_in};
	assign edge_cnt_next = (edge_cnt_reg == `SFCD_EDGES_EXT) ?
		edge_cnt_reg : edge_cnt_reg + 4'h1;
	assign stage_hit[0] = (edge_cnt_reg == `SFCD_EDGES_EXT - 4'h1);
	assign stage_hit[1] = (edge_cnt_reg == `SFCD_EDGES_DUAL - 4'h1);
	assign stage_hit[2] = (edge_cnt_reg == `SFCD_EDGES_QUAD - 4'h1);

	// Opcode bits taken on rising serial clock edges
	always_ff @(posedge sclk_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			edge_cnt_reg <= 4'h0;
			ext_sh_reg   <= 8'h00;
			dual_sh_reg  <= 8'h00;
			quad_sh_reg  <= 8'h00;
		end else begin
			edge_cnt_reg <= edge_cnt_next;
			ext_sh_reg   <= cand[0];
			dual_sh_reg  <= cand[1];
			quad_sh_reg  <= cand[2];
		end
	end

	// Held opcodes and toggles survive the frame end for the crossing
	// opcode line width
	always_ff @(posedge sclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 3; i++) begin
				hold_reg[i] <= 8'h00;
			end
			tog_reg <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (stage_hit[i]) begin
					hold_reg[i] <= cand[i];
				end
			end
			tog_reg <= tog_reg ^ stage_hit;
		end
	end

	// Toggle synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int s = 0; s <= SYNC_STAGES; s++) begin
				sync_reg[s] <= 3'h0;
			end
		end else begin
			sync_reg[0] <= tog_reg;
			for (int s = 1; s <= SYNC_STAGES; s++) begin
				sync_reg[s] <= sync_reg[s-1];
			end
		end
	end

	// Only the stage matching the active protocol starts a decode
	assign stage_ev = sync_reg[SYNC_STAGES-1] ^ sync_reg[SYNC_STAGES];
	assign ev_mine = (proto_in == `SFCD_PROTO_EXT)  ? stage_ev[0] :
		(proto_in == `SFCD_PROTO_DUAL) ? stage_ev[1] :
		(proto_in == `SFCD_PROTO_QUAD) ? stage_ev[2] : 1'b0;
	assign op_pick = by_proto(proto_in, hold_reg[0], hold_reg[1],
		hold_reg[2]);

	// Sequence: capture, table read, emit
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = ev_mine ? ST_LOOK : ST_IDLE;
			ST_LOOK: state_next = ST_EMIT;
			ST_EMIT: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// State and captured opcode; held word is stable once the toggle lands
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg  <= ST_IDLE;
			opcode_reg <= 8'h00;
			proto_reg  <= `SFCD_PROTO_EXT;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && ev_mine) begin
				opcode_reg <= op_pick;
				proto_reg  <= proto_in;
			end
		end
	end

	// Command table, read data registered
	sfcd_cmd_rom u_rom (
		.mclk_in   (mclk_in),
		.rst_n_in  (rst_n_in),
		.op_in     (opcode_reg),
		.entry_out (entry)
	);

	assign emit  = (state_reg == ST_EMIT);
	assign legal = entry.ok[proto_reg];

	assign abytes = (entry.acode == `SFCD_AC_NONE)  ? 3'h0 :
		(entry.acode == `SFCD_AC_THREE) ? `SFCD_ABYTES_3 :
		(entry.acode == `SFCD_AC_FOUR)  ? `SFCD_ABYTES_4 :
		(four_byte_mode_out ? `SFCD_ABYTES_4 : `SFCD_ABYTES_3);

	assign dummy_wide = by_proto(proto_reg, {4'h0, entry.dum_ext},
		{4'h0, entry.dum_dual}, {4'h0, entry.dum_quad});
	assign dummy_sel = dummy_wide[3:0];

	assign clines = lines_for(proto_reg, 3'h1);
	assign alines = (entry.acode == `SFCD_AC_NONE) ? 3'h0 :
		lines_for(proto_reg, entry.ext_alines);
	assign dlines = (entry.dir == `SFCD_DIR_NONE) ? 3'h0 :
		lines_for(proto_reg, entry.ext_dlines);

	assign four_next = (emit && legal && entry.act == `SFCD_ACT_ENTER4) ?
		1'b1 : (emit && legal && entry.act == `SFCD_ACT_EXIT4) ? 1'b0 :
		four_byte_mode_out;

	// Registered description; fields hold until the next legal command
	// data limits and direction
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_valid_out      <= 1'b0;
			cmd_illegal_out    <= 1'b0;
			opcode_out         <= 8'h00;
			cmd_lines_out      <= 3'h0;
			addr_lines_out     <= 3'h0;
			data_lines_out     <= 3'h0;
			addr_bytes_out     <= 3'h0;
			dummy_out          <= 4'h0;
			data_dir_out       <= `SFCD_DIR_NONE;
			data_max_out       <= 5'h00;
			dtr_out            <= 1'b0;
			four_byte_mode_out <= 1'b0;
		end else begin
			cmd_valid_out      <= emit & legal;
			cmd_illegal_out    <= emit & ~legal;
			four_byte_mode_out <= four_next;
			if (emit && legal) begin
				opcode_out     <= opcode_reg;
				cmd_lines_out  <= clines;
				addr_lines_out <= alines;
				data_lines_out <= dlines;
				addr_bytes_out <= abytes;
				dummy_out      <= dummy_sel;
				data_dir_out   <= entry.dir;
				data_max_out   <= entry.dmax;
				dtr_out        <= entry.dtr;
			end
		end
	end

	// Protocol of the command last reported, for the checks below
	logic [1:0] proto_out_chk;
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			proto_out_chk <= `SFCD_PROTO_EXT;
		end else if (emit) begin
			proto_out_chk <= proto_reg;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	AST_DISC: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_DISC |-> addr_bytes_out == 3'h3 &&
		dummy_out == 4'h8 && data_max_out == 5'h00)
		else $error("discovery read phases wrong");
	AST_ID_EXT: assert property (cmd_valid_out &&
		(opcode_out == `SFCD_OP_ID_A || opcode_out == `SFCD_OP_ID_B) |->
		proto_out_chk == `SFCD_PROTO_EXT && data_max_out == 5'h14)
		else $error("single-line id outside extended");
	AST_READ4: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_READ4 |-> addr_bytes_out == 3'h4 &&
		dummy_out == 4'h0 && addr_lines_out == 3'h1)
		else $error("four-byte read phases wrong");
	AST_QIO: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_QIO |-> dummy_out == 4'ha &&
		addr_lines_out == 3'h4 && data_lines_out == 3'h4)
		else $error("quad io read phases wrong");
	AST_DE_QOUT: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_DE_QOUT |-> proto_out_chk !=
		`SFCD_PROTO_DUAL && dummy_out == ((proto_out_chk ==
		`SFCD_PROTO_QUAD) ? 4'h8 : 4'h6))
		else $error("double-edge quad output dummy wrong");
	AST_REGRD: assert property (cmd_valid_out &&
		(opcode_out == `SFCD_OP_RD_FLAG || opcode_out == `SFCD_OP_RD_VCFG ||
		opcode_out == `SFCD_OP_RD_EXTA) |-> addr_bytes_out == 3'h0 &&
		dummy_out == 4'h0 && data_max_out == 5'h00)
		else $error("register read phases wrong");
	AST_GP: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_RD_GP |-> dummy_out == 4'h8 &&
		addr_lines_out == 3'h0)
		else $error("general purpose read dummy wrong");
	AST_ENTER4: assert property (emit && legal &&
		entry.act == `SFCD_ACT_ENTER4 |=> four_byte_mode_out &&
		cmd_valid_out)
		else $error("four-byte mode not entered");
	AST_EXIT4: assert property (emit && legal &&
		entry.act == `SFCD_ACT_EXIT4 |=> !four_byte_mode_out)
		else $error("four-byte mode not left");
	AST_VAR: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_FAST |-> addr_bytes_out ==
		(four_byte_mode_out ? 3'h4 : 3'h3))
		else $error("variable address length wrong");
	AST_LAT: assert property (state_reg == ST_IDLE && ev_mine |->
		##3 (cmd_valid_out || cmd_illegal_out))
		else $error("decode answer not on time");
	AST_DOUT: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_DOUT |-> dummy_out == 4'h8 &&
		proto_out_chk != `SFCD_PROTO_QUAD && data_lines_out == 3'h2)
		else $error("dual output read phases wrong");
	AST_DE_QIO: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_DE_QIO |-> dummy_out == 4'h8 &&
		addr_lines_out == 3'h4 && data_lines_out == 3'h4)
		else $error("double-edge quad io phases wrong");
	AST_DE_DOUT: assert property (cmd_valid_out &&
		opcode_out == `SFCD_OP_DE_DOUT |-> dummy_out == 4'h6 &&
		proto_out_chk != `SFCD_PROTO_QUAD && dtr_out)
		else $error("double-edge dual output phases wrong");
	AST_ILL_HOLD: assert property (cmd_illegal_out |->
		$stable(opcode_out) && !cmd_valid_out)
		else $error("refused opcode changed the fields");

	COV_DISC: cover property (cmd_valid_out &&
		opcode_out == `SFCD_OP_DISC);
	COV_ILLEGAL: cover property (cmd_illegal_out);
	COV_FOUR: cover property (four_byte_mode_out && cmd_valid_out &&
		opcode_out == `SFCD_OP_FAST);
	COV_QUAD: cover property (cmd_valid_out &&
		proto_out_chk == `SFCD_PROTO_QUAD);

endmodule : sfcd_decoder

// File: test/sfcd_host_model.sv
// Purpose: host controller that sends one opcode per frame
// Assumes: serial clock period 48 ns, idle low between frames
// Notes:   only the opcode phase is sent; later phases are not
`timescale 1ns/1ps
module sfcd_host_model (
	output logic       sclk_out,
	output logic       cs_n_out,
	output logic [3:0] dq_out
);
	// Idle bus at time zero
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		dq_out = 4'h0;
	end
	// Frame: data changes after the falling edge, sampled on rising
	task automatic send(input logic [7:0] op, input int w);
		logic [7:0] sh;
		sh = op;
		#1.3 cs_n_out = 1'b0;
		for (int i = 0; i < 8 / w; i++) begin
			dq_out = (w == 1) ? {3'h0, sh[7]} :
				(w == 2) ? {2'h0, sh[7:6]} : sh[7:4];
			sh = sh << w;
			#24 sclk_out = 1'b1;
			#24 sclk_out = 1'b0;
		end
		#24 cs_n_out = 1'b1;
		dq_out = ~dq_out; // Released lines must not keep the last bits
		#48;
	endtask : send
endmodule : sfcd_host_model

// File: test/tb_serial_flash_command_decoder.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: host model drives the serial side
// Notes:   ab value 7 marks an opcode that must be refused
`timescale 1ns/1ps
module tb_serial_flash_command_decoder;
	logic mclk = 1'b0, rst_n = 1'b0, sclk, cs_n, v, fbm, vo, il;
	logic [3:0] dq, dum;
	logic [1:0] proto = 2'h0, dir;
	logic [2:0] ab, dl, cl, al;
	logic [4:0] dmax;
	logic [7:0] opo;
	logic dt;
	int n_errors = 0, total_checks = 0;
	always #2 mclk = ~mclk;
	sfcd_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .dq_out(dq));
	sfcd_decoder DUT (.mclk_in(mclk), .rst_n_in(rst_n), .sclk_in(sclk),
		.cs_n_in(cs_n), .dq_in(dq), .proto_in(proto),
		.cmd_valid_out(vo), .cmd_illegal_out(il), .opcode_out(opo),
		.cmd_lines_out(cl), .addr_lines_out(al), .data_lines_out(dl),
		.addr_bytes_out(ab), .dummy_out(dum), .data_dir_out(dir),
		.data_max_out(dmax), .dtr_out(dt), .four_byte_mode_out(fbm));
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	// One frame; waits for the decode pulse while the frame runs
	task automatic run(input logic [7:0] op, input logic [1:0] p,
			input logic [2:0] eab, input logic [3:0] edm,
			input logic [2:0] edl);
		logic hit;
		logic [2:0] ecl, eal;
		logic edt;
		hit = 1'b0;
		// Opcode lines follow the protocol; address lines per command
		ecl = (p == 2'h0) ? 3'h1 : (p == 2'h1) ? 3'h2 : 3'h4;
		eal = (eab == 3'h0) ? 3'h0 : (p != 2'h0) ? ecl :
			(op == 8'heb || op == 8'hed) ? 3'h4 :
			(op == 8'hbd || op == 8'hbe) ? 3'h2 : 3'h1;
		edt = (op == 8'h0d || op == 8'h3d || op == 8'hbd ||
			op == 8'h6d || op == 8'hed || op == 8'h0e ||
			op == 8'hbe || op == 8'hee);
		@(negedge mclk);
		proto = p;
		// Bound covers an eight-edge frame plus the crossing delay
		fork
			host.send(op, (p == 2'h0) ? 1 : (p == 2'h1) ? 2 : 4);
			for (int k = 0; k < 200 && !hit; k++) begin
				@(negedge mclk);
				hit = (vo === 1'b1 || il === 1'b1);
				v = vo;
			end
		join
		cmp({4'h0, hit}, 5'h01);
		cmp({4'h0, v}, {4'h0, eab != 3'h7});
		if (eab != 3'h7 && v === 1'b1) begin
			cmp({2'h0, ab}, {2'h0, eab});
			cmp({1'b0, dum}, {1'b0, edm});
			cmp({2'h0, dl}, {2'h0, edl});
			cmp({1'b0, opo[7:4]}, {1'b0, op[7:4]});
			cmp({1'b0, opo[3:0]}, {1'b0, op[3:0]});
			cmp({2'h0, cl}, {2'h0, ecl});
			cmp({2'h0, al}, {2'h0, eal});
			cmp({4'h0, dt}, {4'h0, edt});
		end
	endtask : run
	task automatic t_id_disc();
		run(8'h5a, 2'h0, 3'h3, 4'h8, 3'h1);
		run(8'h5a, 2'h2, 3'h3, 4'h8, 3'h4);
		run(8'haf, 2'h2, 3'h0, 4'h0, 3'h4);
		cmp(dmax, 5'h14);
		run(8'h9e, 2'h0, 3'h0, 4'h0, 3'h1);
		run(8'h9f, 2'h2, 3'h7, 4'h0, 3'h0);
		$display("done: id and discovery");
	endtask : t_id_disc
	task automatic t_reads();
		run(8'h13, 2'h0, 3'h4, 4'h0, 3'h1);
		run(8'h13, 2'h1, 3'h7, 4'h0, 3'h0);
		run(8'h3b, 2'h0, 3'h3, 4'h8, 3'h2);
		run(8'h3b, 2'h1, 3'h3, 4'h8, 3'h2);
		run(8'heb, 2'h0, 3'h3, 4'ha, 3'h4);
		run(8'heb, 2'h2, 3'h3, 4'ha, 3'h4);
		run(8'h6d, 2'h0, 3'h3, 4'h6, 3'h4);
		run(8'h6d, 2'h2, 3'h3, 4'h8, 3'h4);
		run(8'h6d, 2'h1, 3'h7, 4'h0, 3'h0);
		run(8'hed, 2'h2, 3'h3, 4'h8, 3'h4);
		run(8'h3d, 2'h0, 3'h3, 4'h6, 3'h2);
		run(8'h3d, 2'h2, 3'h7, 4'h0, 3'h0);
		run(8'hbd, 2'h1, 3'h3, 4'h6, 3'h2);
		run(8'h0e, 2'h1, 3'h4, 4'h6, 3'h2);
		run(8'h0e, 2'h2, 3'h4, 4'h8, 3'h4);
		run(8'h3c, 2'h1, 3'h4, 4'h8, 3'h2);
		run(8'hbe, 2'h0, 3'h4, 4'h6, 3'h2);
		$display("done: memory reads");
	endtask : t_reads
	task automatic t_regs();
		run(8'h70, 2'h1, 3'h0, 4'h0, 3'h2);
		cmp({3'h0, dir}, 5'h01);
		cmp(dmax, 5'h00);
		run(8'h85, 2'h2, 3'h0, 4'h0, 3'h4);
		run(8'hc8, 2'h0, 3'h0, 4'h0, 3'h1);
		run(8'h96, 2'h1, 3'h0, 4'h8, 3'h2);
		run(8'hb1, 2'h2, 3'h0, 4'h0, 3'h4);
		cmp({3'h0, dir}, 5'h02);
		cmp(dmax, 5'h02);
		$display("done: register commands");
	endtask : t_regs
	task automatic t_mode();
		run(8'h0b, 2'h0, 3'h3, 4'h8, 3'h1);
		run(8'hb7, 2'h2, 3'h0, 4'h0, 3'h0);
		cmp({4'h0, fbm}, 5'h01);
		run(8'h0b, 2'h2, 3'h4, 4'ha, 3'h4);
		run(8'heb, 2'h2, 3'h4, 4'ha, 3'h4);
		run(8'h5a, 2'h0, 3'h3, 4'h8, 3'h1);
		run(8'he9, 2'h1, 3'h0, 4'h0, 3'h0);
		cmp({4'h0, fbm}, 5'h00);
		run(8'heb, 2'h0, 3'h3, 4'ha, 3'h4);
		run(8'h13, 2'h0, 3'h4, 4'h0, 3'h1);
		$display("done: address mode");
	endtask : t_mode
	// Watchdog: about twenty times the expected run
	initial begin
		#200000;
		n_errors++;
		conclude();
	end
	initial begin
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		repeat (5) @(negedge mclk);
		t_id_disc();
		t_reads();
		t_regs();
		t_mode();
		conclude();
	end
endmodule : tb_serial_flash_command_decoder
